// ### hw/rxirq_regs.sv
// Purpose: Interrupt enable and latched flag registers for five receiver events,
//          wanted SYSREF-to-LMFC delay settings, sync mode and jitter window,
//          and the read-only grade and revision byte.
// Assumes: The configuration port delivers one-cycle write and read strobes with
//          a byte address, synchronous to clk.
// Notes:   Read data appear one cycle after the read strobe and hold until the next.
`timescale 1ns/1ps
`include "rxirq_consts.svh"

module rxirq_regs #(
    parameter logic [3:0] GRADE    = 4'h0, // Arbitrary value
    parameter logic [3:0] REVISION = 4'h0  // Arbitrary value
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // Configuration register port
    input  wire logic [`RXIRQ_ADDR_W-1:0] reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [7:0]               reg_wdata,
    output logic      [7:0]               reg_rdata,
    // Receiver event sources
    input  wire logic                     rx_link_ready,
    input  wire logic                     lane_fifo_err,
    input  wire logic                     prbs_imag_err,
    input  wire logic                     prbs_real_err,
    // Sync engine
    input  wire logic                     sysref_evt,
    input  wire logic [`RXIRQ_DLY_W-1:0]  measured_delay,
    output logic      [`RXIRQ_FRM_W-1:0]  align_delay_frames,
    output logic      [`RXIRQ_DLY_W-1:0]  align_delay_clocks,
    output logic      [`RXIRQ_MODE_W-1:0] sync_mode,
    output logic                          lmfc_realign,
    // Interrupt request
    output logic                          irq
);

    // Software-visible state
    logic [`RXIRQ_NUM_EVT-1:0] irq_en_q;
    logic [`RXIRQ_NUM_EVT-1:0] flags_q, flags_d;
    logic [`RXIRQ_FRM_W-1:0]   dly_frm_q;
    logic [7:0]                dly_lo_q;
    logic [3:0]                dly_hi_q;
    logic [`RXIRQ_WIN_W-1:0]   jit_win_q;
    logic [`RXIRQ_MODE_W-1:0]  mode_q;
    logic [7:0]                rdata_q, rdata_d;
    logic                      irq_q;

    rxirq_sync_if sync ();

    // Returns true when a write hits the given offset
    function automatic logic wr_hit(input logic [`RXIRQ_ADDR_W-1:0] ofs);
        wr_hit = reg_wr && (reg_addr == ofs);
    endfunction

    // Write decode
    wire logic wr_en    = wr_hit(`RXIRQ_OFS_IRQ_EN);
    wire logic wr_flags = wr_hit(`RXIRQ_OFS_IRQ_FLAGS);
    wire logic wr_frm   = wr_hit(`RXIRQ_OFS_DLY_FRM);
    wire logic wr_lo    = wr_hit(`RXIRQ_OFS_DLY_LO);
    wire logic wr_hi    = wr_hit(`RXIRQ_OFS_DLY_HI);
    wire logic wr_win   = wr_hit(`RXIRQ_OFS_JIT_WIN);
    wire logic wr_mode  = wr_hit(`RXIRQ_OFS_SYNC_CTRL);

    // Hardware set terms, one per flag bit
    wire logic [`RXIRQ_NUM_EVT-1:0] evt_set;
    assign evt_set[`RXIRQ_BIT_JITTER]    = sync.jitter_evt;
    assign evt_set[`RXIRQ_BIT_RX_READY]  = ~rx_link_ready;
    assign evt_set[`RXIRQ_BIT_LANE_FIFO] = lane_fifo_err;
    assign evt_set[`RXIRQ_BIT_PRBS_IMAG] = prbs_imag_err;
    assign evt_set[`RXIRQ_BIT_PRBS_REAL] = prbs_real_err;

    // Write-one-to-clear mask; zeros written elsewhere leave other flags alone
    wire logic [`RXIRQ_NUM_EVT-1:0] clr_mask =
        wr_flags ? reg_wdata[`RXIRQ_NUM_EVT-1:0] : `RXIRQ_RST_EVT;

    // Per-bit flag update: a set in the clearing cycle wins so no event is lost.
    // Ready-low keeps re-setting while the receiver stays down.
    genvar gi;
    generate
        for (gi = 0; gi < `RXIRQ_NUM_EVT; gi++) begin : g_flag
            assign flags_d[gi] = evt_set[gi] | (flags_q[gi] & ~clr_mask[gi]);
        end
    endgenerate

    // Interrupt request: any latched flag whose enable is set
    wire logic irq_d = |(flags_q & irq_en_q);

    // Enable register with each bit gating its own event
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_en_q <= `RXIRQ_RST_EVT;
        end else if (wr_en) begin
            irq_en_q <= reg_wdata[`RXIRQ_NUM_EVT-1:0];
        end
    end

    // Latched event flags
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= `RXIRQ_RST_EVT;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Wanted LMFC delay in frames
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dly_frm_q <= `RXIRQ_RST_FRM;
        end else if (wr_frm) begin
            dly_frm_q <= reg_wdata[`RXIRQ_FRM_W-1:0];
        end
    end

    // Wanted LMFC delay in DAC clocks, two bytes written independently.
    // No shadowing: the sync engine can see a half-updated value between writes.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dly_lo_q <= `RXIRQ_RST_BYTE;
            dly_hi_q <= 4'h0;
        end else begin
            if (wr_lo) begin
                dly_lo_q <= reg_wdata;
            end
            if (wr_hi) begin
                dly_hi_q <= reg_wdata[3:0];
            end
        end
    end

    // Jitter window and sync mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            jit_win_q <= `RXIRQ_RST_WIN;
            mode_q    <= `RXIRQ_RST_MODE;
        end else begin
            if (wr_win) begin
                jit_win_q <= reg_wdata[`RXIRQ_WIN_W-1:0];
            end
            if (wr_mode) begin
                mode_q <= reg_wdata[`RXIRQ_MODE_W-1:0];
            end
        end
    end

    // Read mux; reserved bits and unmapped offsets read as zero
    always_comb begin
        rdata_d = `RXIRQ_RST_BYTE;
        unique case (reg_addr)
            `RXIRQ_OFS_GRADE:     rdata_d = {GRADE, REVISION};
            `RXIRQ_OFS_IRQ_EN:    rdata_d = {3'h0, irq_en_q};
            `RXIRQ_OFS_IRQ_FLAGS: rdata_d = {3'h0, flags_q};
            `RXIRQ_OFS_DLY_FRM:   rdata_d = {3'h0, dly_frm_q};
            `RXIRQ_OFS_DLY_LO:    rdata_d = dly_lo_q;
            `RXIRQ_OFS_DLY_HI:    rdata_d = {4'h0, dly_hi_q};
            `RXIRQ_OFS_JIT_WIN:   rdata_d = {2'h0, jit_win_q};
            `RXIRQ_OFS_SYNC_CTRL: rdata_d = {6'h00, mode_q};
            default:              rdata_d = `RXIRQ_RST_BYTE;
        endcase
    end

    // Read data and interrupt come from flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= `RXIRQ_RST_BYTE;
            irq_q   <= 1'b0;
        end else begin
            irq_q <= irq_d;
            if (reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Settings toward the monitor
    assign sync.window = jit_win_q;
    assign sync.mode   = mode_q;

    // SYSREF jitter monitor and realign sequencing
    rxirq_jitter_mon u_mon (
        .clk            (clk),
        .resetn         (resetn),
        .sysref_evt     (sysref_evt),
        .measured_delay (measured_delay),
        .sync           (sync)
    );

    // Outputs
    assign reg_rdata          = rdata_q;
    assign align_delay_frames = dly_frm_q;
    assign align_delay_clocks = {dly_hi_q, dly_lo_q};
    assign sync_mode          = mode_q;
    assign lmfc_realign       = sync.realign;
    assign irq                = irq_q;

endmodule

// ### pkg/rxirq_consts.svh
// Purpose: Offsets, field positions, reset values and widths for the receiver
//          interrupt and LMFC delay register group.
// Assumes: Byte-wide registers at their printed offsets on the config port.
// Notes:   Definitions only.
//
// Behaviour
// - Bit 4 of the enable register switches the SYSREF jitter interrupt off (0) or on (1).
// - Flag bit 4 is set when SYSREF jitter is too large and is cleared by writing a one to it.
// - Bit 3 of the enable register switches the receiver-ready-low interrupt off or on.
// - Flag bit 3 is set while the receiver ready indication is low; a written one clears it.
// - Bit 2 of the enable register switches the lane FIFO over/underflow interrupt off or on.
// - Flag bit 2 is set on any lane FIFO overflow or underflow; a written one clears it.
// - Bit 1 of the enable register switches the imaginary-path PRBS error interrupt off or on.
// - Flag bit 1 is set on an imaginary-path PRBS error; a written one clears it.
// - Bit 0 of the enable register switches the real-path PRBS error interrupt off or on.
// - Flag bit 0 is set on a real-path PRBS error; a written one clears it.
// - A writable 5-bit field holds the wanted SYSREF-to-LMFC delay in frames.
// - A writable 12-bit wanted delay in DAC clocks is split as low byte plus upper nibble.
// - A 2-bit mode picks monitor only, realign on every SYSREF, or realign once then monitor.
// - Jitter is flagged when SYSREF timing moves by more than a 6-bit window, low 2 bits ignored.
`ifndef RXIRQ_CONSTS_SVH
`define RXIRQ_CONSTS_SVH

// Register offsets
`define RXIRQ_ADDR_W         12
`define RXIRQ_OFS_GRADE      12'h006
`define RXIRQ_OFS_IRQ_EN     12'h020
`define RXIRQ_OFS_IRQ_FLAGS  12'h024
`define RXIRQ_OFS_DLY_FRM    12'h031
`define RXIRQ_OFS_DLY_LO     12'h032
`define RXIRQ_OFS_DLY_HI     12'h033
`define RXIRQ_OFS_JIT_WIN    12'h039
`define RXIRQ_OFS_SYNC_CTRL  12'h03A

// Event bit positions, shared by enable and flag registers
`define RXIRQ_BIT_PRBS_REAL  0
`define RXIRQ_BIT_PRBS_IMAG  1
`define RXIRQ_BIT_LANE_FIFO  2
`define RXIRQ_BIT_RX_READY   3
`define RXIRQ_BIT_JITTER     4
`define RXIRQ_NUM_EVT        5

// Field widths
`define RXIRQ_FRM_W          5
`define RXIRQ_DLY_W          12
`define RXIRQ_WIN_W          6
`define RXIRQ_WIN_IGNORE     2
`define RXIRQ_MODE_W         2

// Reset values
`define RXIRQ_RST_EVT        5'h00
`define RXIRQ_RST_FRM        5'h00
`define RXIRQ_RST_DLY        12'h000
`define RXIRQ_RST_WIN        6'h00
`define RXIRQ_RST_MODE       2'h0
`define RXIRQ_RST_BYTE       8'h00

`endif

// ### pkg/rxirq_pkg.sv
// Purpose: Types for the receiver interrupt and LMFC delay register group.
// Assumes: Constants live in rxirq_consts.svh.
// Notes:   Mode codes follow declaration order: 0 monitor, 1 continuous, 2 one-shot.
package rxirq_pkg;

    // Synchronisation behaviour selected by software
    typedef enum logic [1:0] {
        RXIRQ_MODE_MONITOR,
        RXIRQ_MODE_CONT,
        RXIRQ_MODE_ONESHOT
    } rxirq_sync_mode_t;

    // Jitter monitor tracking state
    typedef enum logic {
        RXIRQ_MON_NOREF,
        RXIRQ_MON_TRACK
    } rxirq_mon_state_t;

endpackage

// ### pkg/rxirq_sync_if.sv
// Purpose: Carrier between the register bank and the SYSREF jitter monitor.
// Assumes: One clock domain.
// Notes:   Bank drives settings, monitor returns events.
`timescale 1ns/1ps
`include "rxirq_consts.svh"

interface rxirq_sync_if;
    logic [`RXIRQ_WIN_W-1:0]  window;
    logic [`RXIRQ_MODE_W-1:0] mode;
    logic                     jitter_evt;
    logic                     realign;

    modport bank (output window, output mode, input jitter_evt, input realign);
    modport mon  (input window, input mode, output jitter_evt, output realign);
endinterface

// ### hw/rxirq_jitter_mon.sv
// Purpose: Watch measured SYSREF-to-LMFC delays, request LMFC realignment per mode
//          and pulse a jitter event when the delay wanders beyond the window.
// Assumes: sysref_evt is a one-cycle pulse with measured_delay valid beside it.
// Notes:   The first SYSREF after reset, or after a realign made while tracking, becomes the reference.
`timescale 1ns/1ps
`include "rxirq_consts.svh"

module rxirq_jitter_mon (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    resetn,
    // Measurement from the sync engine
    input  wire logic                    sysref_evt,
    input  wire logic [`RXIRQ_DLY_W-1:0] measured_delay,
    // Link to the register bank
    rxirq_sync_if.mon                    sync
);

    rxirq_pkg::rxirq_mon_state_t state_q, state_d;
    logic [`RXIRQ_DLY_W-1:0] ref_q;
    logic                    oneshot_done_q;
    logic                    jitter_q;
    logic                    realign_q;

    wire logic [`RXIRQ_DLY_W-1:0] diff;
    wire logic                    too_far;
    wire logic                    mode_cont;
    wire logic                    mode_one;
    wire logic                    do_realign;

    // Distance from the reference; the window's two low bits carry no weight
    assign diff    = (measured_delay >= ref_q) ? measured_delay - ref_q
                                               : ref_q - measured_delay;
    assign too_far = diff[`RXIRQ_DLY_W-1:`RXIRQ_WIN_IGNORE] >
                     {6'h00, sync.window[`RXIRQ_WIN_W-1:`RXIRQ_WIN_IGNORE]};

    // Mode decode; the unused code 3 behaves as monitor only
    assign mode_cont  = (sync.mode == rxirq_pkg::RXIRQ_MODE_CONT);
    assign mode_one   = (sync.mode == rxirq_pkg::RXIRQ_MODE_ONESHOT);
    assign do_realign = sysref_evt & (mode_cont | (mode_one & ~oneshot_done_q));

    // A realign moves the LMFC, so the old reference no longer means anything
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            rxirq_pkg::RXIRQ_MON_NOREF: begin
                if (sysref_evt) begin
                    state_d = rxirq_pkg::RXIRQ_MON_TRACK;
                end
            end
            rxirq_pkg::RXIRQ_MON_TRACK: begin
                if (do_realign) begin
                    state_d = rxirq_pkg::RXIRQ_MON_NOREF;
                end
            end
        endcase
    end

    // Reference, one-shot memory and output pulses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q        <= rxirq_pkg::RXIRQ_MON_NOREF;
            ref_q          <= `RXIRQ_RST_DLY;
            oneshot_done_q <= 1'b0;
            jitter_q       <= 1'b0;
            realign_q      <= 1'b0;
        end else begin
            state_q   <= state_d;
            jitter_q  <= sysref_evt & ~do_realign &
                         (state_q == rxirq_pkg::RXIRQ_MON_TRACK) & too_far;
            realign_q <= do_realign;
            if (sysref_evt && state_q == rxirq_pkg::RXIRQ_MON_NOREF) begin
                ref_q <= measured_delay;
            end
            if (!mode_one) begin
                oneshot_done_q <= 1'b0; // Re-arms when one-shot is reselected
            end else if (do_realign) begin
                oneshot_done_q <= 1'b1;
            end
        end
    end

    assign sync.jitter_evt = jitter_q;
    assign sync.realign    = realign_q;

endmodule

// ### sim/rxirq_host.sv
// Purpose: Configuration host model on the register port.
// Assumes: Strobes change 1 ns after a rising edge.
// Notes:   Idle address and data show the inverse of the last value.
`timescale 1ns/1ps
`include "rxirq_consts.svh"
module rxirq_host (
    // Clock
    input  wire logic                     clk,
    // Register port
    output logic      [`RXIRQ_ADDR_W-1:0] reg_addr,
    output logic                          reg_wr,
    output logic                          reg_rd,
    output logic      [7:0]               reg_wdata,
    input  wire logic [7:0]               reg_rdata
);
    // Quiet port from time zero
    initial begin
        reg_addr  = 12'hFFF;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'hFF;
    end
    // One write strobe, held across exactly one sampling edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk) #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // Read data are taken once the sampling edge has landed
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk) #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask
endmodule

// ### sim/rxirq_regs_assertions.sv
// Purpose: Port-level checks on the register group.
// Assumes: One clock domain, reset active low.
// Notes:   Flags are only visible through reads.
`timescale 1ns/1ps
`include "rxirq_consts.svh"
module rxirq_regs_assertions (
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // Events and sync
    input wire logic        rx_link_ready,
    input wire logic        lane_fifo_err,
    input wire logic        prbs_imag_err,
    input wire logic        prbs_real_err,
    input wire logic        sysref_evt,
    input wire logic [11:0] measured_delay,
    input wire logic [4:0]  align_delay_frames,
    input wire logic [11:0] align_delay_clocks,
    input wire logic [1:0]  sync_mode,
    input wire logic        lmfc_realign,
    input wire logic        irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Decoded strobes
    wire wr_frm = reg_wr && reg_addr == `RXIRQ_OFS_DLY_FRM;
    wire wr_lo  = reg_wr && reg_addr == `RXIRQ_OFS_DLY_LO;
    wire wr_hi  = reg_wr && reg_addr == `RXIRQ_OFS_DLY_HI;
    wire wr_mod = reg_wr && reg_addr == `RXIRQ_OFS_SYNC_CTRL;
    wire rd_flg = reg_rd && reg_addr == `RXIRQ_OFS_IRQ_FLAGS;
    // Written fields as plain signals for the sampled-value functions
    wire [4:0] wd_frm = reg_wdata[4:0];
    wire [3:0] wd_hi  = reg_wdata[3:0];
    wire [1:0] wd_mod = reg_wdata[1:0];
    // An event at one edge must show in a flag read at the next
    sequence s_evt_read(ev);
        ev ##1 rd_flg;
    endsequence
    a_frames_write: assert property (
        wr_frm |=> align_delay_frames == $past(wd_frm))
        else $error("frames delay not written");
    a_clocks_low: assert property (
        wr_lo |=> align_delay_clocks[7:0] == $past(reg_wdata))
        else $error("clock delay low byte not written");
    a_clocks_high: assert property (
        wr_hi |=> align_delay_clocks[11:8] == $past(wd_hi))
        else $error("clock delay nibble not written");
    a_mode_write: assert property (
        wr_mod |=> sync_mode == $past(wd_mod))
        else $error("sync mode not written");
    a_realign_cause: assert property (
        lmfc_realign |-> $past(sysref_evt) && ($past(sync_mode) inside {2'h1, 2'h2}))
        else $error("realign without cause");
    a_cont_realign: assert property (
        sync_mode == 2'h1 && sysref_evt |=> lmfc_realign)
        else $error("continuous mode missed realign");
    a_ready_flag: assert property (
        s_evt_read(!rx_link_ready) |=> reg_rdata[3])
        else $error("ready low flag not latched");
    a_fifo_flag: assert property (
        s_evt_read(lane_fifo_err) |=> reg_rdata[2])
        else $error("fifo flag not latched");
    a_prbs_flag: assert property (
        s_evt_read(prbs_real_err) |=> reg_rdata[0])
        else $error("real prbs flag not latched");
endmodule
bind rxirq_regs rxirq_regs_assertions i_rxirq_regs_assertions (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_link_ready(rx_link_ready),
    .lane_fifo_err(lane_fifo_err), .prbs_imag_err(prbs_imag_err),
    .prbs_real_err(prbs_real_err), .sysref_evt(sysref_evt), .measured_delay(measured_delay),
    .align_delay_frames(align_delay_frames), .align_delay_clocks(align_delay_clocks),
    .sync_mode(sync_mode), .lmfc_realign(lmfc_realign), .irq(irq));

// ### sim/rxirq_regs_test.sv
// Purpose: Self-checking bench for the interrupt and delay registers.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   An integer map model predicts every read.
`timescale 1ns/1ps
`include "rxirq_consts.svh"
module rxirq_regs_test;
    logic        clk;
    logic        resetn;
    logic [11:0] reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [4:0]  evt;
    logic        sysref_evt;
    logic [11:0] measured_delay;
    logic [4:0]  frm;
    logic [11:0] dly;
    logic [1:0]  mode;
    logic        realign;
    logic        irq;
    logic [7:0]  rd_v;
    int          err_count;
    int          checks_done;
    int          seed;
    int          flags;
    int          a;
    int          model [int];
    int          mask [int];
    int          addrs [9] = '{'h006, 'h020, 'h024, 'h031, 'h032, 'h033, 'h039, 'h03A, 'h100};
    int          jit [5] = '{100, 103, 106, 97, 108};

    // Device with arbitrary grade and revision
    rxirq_regs #(.GRADE(4'h5), .REVISION(4'hA)) i_rxirq_regs (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_link_ready(~evt[3]),
        .lane_fifo_err(evt[2]), .prbs_imag_err(evt[1]), .prbs_real_err(evt[0]),
        .sysref_evt(sysref_evt), .measured_delay(measured_delay),
        .align_delay_frames(frm), .align_delay_clocks(dly), .sync_mode(mode),
        .lmfc_realign(realign), .irq(irq));
    rxirq_host i_rxirq_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // Write through the host and update the model; flags clear where ones are written
    task automatic mwr(input int ad, input int d);
        i_rxirq_host.wr(ad[11:0], d[7:0]);
        if (ad == `RXIRQ_OFS_IRQ_FLAGS) flags = flags & ~d;
        else if (mask.exists(ad)) model[ad] = d & mask[ad];
    endtask
    task automatic mrd(input int ad);
        int e;
        i_rxirq_host.rd(ad[11:0], rd_v);
        e = (ad == `RXIRQ_OFS_IRQ_FLAGS) ? flags : (ad == `RXIRQ_OFS_GRADE) ? 'h5A :
            model.exists(ad) ? model[ad] : 0;
        chk("read data", e[11:0], {4'h0, rd_v});
    endtask
    // One-cycle receiver event
    task automatic pulse(input int b);
        @(posedge clk) #1;
        evt[b] = 1'b1;
        @(posedge clk) #1;
        evt[b] = 1'b0;
        flags  = flags | (1 << b);
    endtask
    // One SYSREF measurement; delay lines are scrambled outside the pulse
    task automatic ref_pulse(input int d);
        @(posedge clk) #1;
        sysref_evt     = 1'b1;
        measured_delay = d[11:0];
        @(posedge clk) #1;
        sysref_evt     = 1'b0;
        measured_delay = ~d[11:0];
    endtask
    task automatic stop_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #2000000;
        err_count++;
        stop_test();
    end
    // Main sequence
    initial begin
        resetn         = 1'b0;
        evt            = 5'h00;
        sysref_evt     = 1'b0;
        measured_delay = 12'h000;
        seed           = 9116;
        flags          = 0;
        mask = '{'h020: 'h1F, 'h031: 'h1F, 'h032: 'hFF, 'h033: 'h0F, 'h039: 'h3F, 'h03A: 'h03};
        foreach (mask[k]) model[k] = 0;
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
        foreach (addrs[k]) mrd(addrs[k]);
        // Random writes and read-back over mapped, read-only and unmapped places
        for (int i = 0; i < 30; i++) begin
            a = addrs[$unsigned($random(seed)) % 9];
            mwr(a, $random(seed));
            mrd(a);
            chk("frames", model['h031], {7'h00, frm});
            chk("clocks", (model['h033] << 8) | model['h032], dly);
        end
        // Events 0 to 3 each masked then enabled, then cleared
        for (int b = 0; b < 4; b++) begin
            for (int e = 0; e < 2; e++) begin
                mwr(`RXIRQ_OFS_IRQ_EN, e << b);
                pulse(b);
                @(posedge clk) #1;
                chk("irq", e, irq);
                mrd(`RXIRQ_OFS_IRQ_FLAGS);
                mwr(`RXIRQ_OFS_IRQ_FLAGS, 1 << b);
                mrd(`RXIRQ_OFS_IRQ_FLAGS);
                chk("irq", 0, irq);
            end
        end
        // Event then a flag read on the very next edge, so the latch checkers for bits 0, 2 and 3 fire
        for (int b = 0; b < 4; b++) begin
            fork
                pulse(b);
                begin
                    @(posedge clk);
                    mrd(`RXIRQ_OFS_IRQ_FLAGS);
                end
            join
            mwr(`RXIRQ_OFS_IRQ_FLAGS, 1 << b);
        end
        // Jitter window 4: only the last sample moves more than one step
        mwr(`RXIRQ_OFS_SYNC_CTRL, 0);
        mwr(`RXIRQ_OFS_JIT_WIN, 4);
        mwr(`RXIRQ_OFS_IRQ_EN, 'h10);
        foreach (jit[k]) begin
            ref_pulse(jit[k]);
            @(posedge clk) #1;
            if (k == 4) flags = flags | 'h10;
            mrd(`RXIRQ_OFS_IRQ_FLAGS);
            chk("irq", k == 4, irq);
        end
        mwr(`RXIRQ_OFS_IRQ_FLAGS, 'h10);
        // Every mode code with two measurements
        for (int m = 0; m < 4; m++) begin
            mwr(`RXIRQ_OFS_SYNC_CTRL, m);
            chk("sync mode", m, mode);
            ref_pulse(100);
            chk("realign", m == 1 || m == 2, realign);
            ref_pulse(100);
            chk("realign", m == 1, realign);
        end
        mrd(`RXIRQ_OFS_IRQ_FLAGS);
        stop_test();
    end
endmodule
